// file: common/pattern_pkg.sv
package pattern_pkg;
	// ==========================================================
	// Geometry
	localparam int                  NUM_LINES    = 16;
	localparam int                  SER_FACTOR   = 14;
	localparam int                  ADC_BITS     = 14;
	localparam int                  CUSTOM_BITS  = 16;
	localparam int                  PRBS_BITS    = 23;
	localparam int                  PRBS_OUT     = 16;
	// Ramp step 2^(S-N) in serialized-word units
	localparam logic [13:0]         RAMP_STEP    = 14'(1 << (SER_FACTOR - ADC_BITS));
	localparam logic [13:0]         RAMP_START   = 14'h2000;
	localparam logic [22:0]         PRBS_SEED    = 23'h7FFFFF;
	localparam logic [31:0]         CUSTOM_RESET = 32'h00000000;

	// ==========================================================
	// Pattern encodings of the three-bit select fields
	localparam logic [2:0]          PAT_NONE     = 3'h0;
	localparam logic [2:0]          PAT_ZEROS    = 3'h1;
	localparam logic [2:0]          PAT_ONES     = 3'h2;
	localparam logic [2:0]          PAT_DESKEW   = 3'h3;
	localparam logic [2:0]          PAT_SYNC     = 3'h4;
	localparam logic [2:0]          PAT_CUSTOM   = 3'h5;
	localparam logic [2:0]          PAT_RAMP     = 3'h6;
	localparam logic [2:0]          PAT_TOGGLE   = 3'h7;

	localparam logic [13:0]         WORD_DESKEW  = 14'h1555;
	localparam logic [13:0]         WORD_SYNC    = 14'h3F80;

	// ==========================================================
	// APB register byte offsets
	localparam logic [11:0]         OFS_CTRL     = 12'h000;
	localparam logic [11:0]         OFS_CUSTOM   = 12'h004;
	localparam logic [11:0]         OFS_LSEL_LO  = 12'h008;
	localparam logic [11:0]         OFS_LSEL_HI  = 12'h00C;
	localparam logic [11:0]         OFS_LPRBS    = 12'h010;
	localparam logic [11:0]         OFS_STATUS   = 12'h014;

	// CTRL field positions
	localparam int                  CTRL_GSEL    = 0;
	localparam int                  CTRL_IND     = 3;
	localparam int                  CTRL_GPRBS   = 4;
	localparam int                  CTRL_RAND_EN = 5;
	localparam int                  CTRL_LEN9    = 6;
	localparam int                  CTRL_RESTART = 7;

	// Generator state phases
	typedef enum logic [1:0] {
		GEN_IDLE = 2'b01,
		GEN_RUN  = 2'b10
	} gen_state_t;

	// Per-line pattern selector: 2^N-wrapped fixed words
	function automatic logic [13:0] fixed_word(input logic [2:0] sel,
		input logic [15:0] custom);
		case (sel)
			PAT_ZEROS:  fixed_word = 14'h0000;
			PAT_ONES:   fixed_word = 14'h3FFF;
			PAT_DESKEW: fixed_word = WORD_DESKEW;
			PAT_SYNC:   fixed_word = WORD_SYNC;
			PAT_CUSTOM: fixed_word = custom[15:2];
			default:    fixed_word = 14'h0000;
		endcase
	endfunction : fixed_word
endpackage : pattern_pkg

// file: common/gen_if.sv
interface gen_if;
	logic        restart;
	logic        len9;
	logic        toggle_clear;
	logic [13:0] ramp_word;
	logic        toggle_bit;
	logic [15:0] prbs_word;
	logic        running;

	modport gen (input restart, input len9, input toggle_clear,
		output ramp_word, output toggle_bit, output prbs_word, output running);
	modport user (output restart, output len9, output toggle_clear,
		input ramp_word, input toggle_bit, input prbs_word, input running);
endinterface : gen_if

// file: hw/pattern_generators.sv
module pattern_generators (
	input  wire logic pclk,
	input  wire logic presetn,
	gen_if.gen        gio
);
	typedef struct packed {
		pattern_pkg::gen_state_t phase;
		logic [13:0]             ramp;
		logic                    toggle;
		logic [22:0]             lfsr;
	} gen_st_t;

	gen_st_t st_reg;
	gen_st_t st_next;

	// ==========================================================
	// Free-running generators, one step per conversion clock
	always_comb begin
		st_next = st_reg;
		st_next.phase = pattern_pkg::GEN_RUN;
		st_next.ramp = 14'(st_reg.ramp + pattern_pkg::RAMP_STEP);
		st_next.toggle = ~st_reg.toggle;
		if (gio.len9) begin
			// Nine-bit polynomial x^9+x^5+1 lives in the top bits
			st_next.lfsr = {st_reg.lfsr[21:14], st_reg.lfsr[22] ^ st_reg.lfsr[18],
				st_reg.lfsr[13:0]};
		end else begin
			st_next.lfsr = {st_reg.lfsr[21:0], st_reg.lfsr[22] ^ st_reg.lfsr[17]};
		end
		if (gio.toggle_clear) begin
			st_next.toggle = 1'b0;
		end
		if (gio.restart) begin
			// Restart holds all sequences at their origin
			st_next.phase = pattern_pkg::GEN_IDLE;
			st_next.ramp = pattern_pkg::RAMP_START;
			st_next.toggle = 1'b0;
			st_next.lfsr = pattern_pkg::PRBS_SEED;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{pattern_pkg::GEN_IDLE, pattern_pkg::RAMP_START, 1'b0,
				pattern_pkg::PRBS_SEED};
		end else begin
			st_reg <= st_next;
		end
	end

	assign gio.ramp_word = st_reg.ramp;
	assign gio.toggle_bit = st_reg.toggle;
	assign gio.prbs_word = st_reg.lfsr[22:7];
	assign gio.running = (st_reg.phase == pattern_pkg::GEN_RUN);

	// ==========================================================
	// Checks
	chk_ramp_step: assert property (@(posedge pclk) disable iff (!presetn)
		!gio.restart |=> st_reg.ramp == 14'($past(st_reg.ramp) + 14'h0001))
		else $error("ramp did not advance by one step");
	chk_toggle_alt: assert property (@(posedge pclk) disable iff (!presetn)
		(!gio.restart && !gio.toggle_clear) |=> st_reg.toggle != $past(st_reg.toggle))
		else $error("toggle did not alternate");
	chk_prbs_restart: assert property (@(posedge pclk) disable iff (!presetn)
		gio.restart |=> st_reg.lfsr == pattern_pkg::PRBS_SEED)
		else $error("restart did not reseed generator");
	chk_ramp_origin: assert property (@(posedge pclk) disable iff (!presetn)
		gio.restart |=> st_reg.ramp == pattern_pkg::RAMP_START)
		else $error("restart did not return ramp to negative full scale");
	cov_ramp_wrap: cover property (@(posedge pclk) disable iff (!presetn)
		st_reg.ramp == 14'h3FFF ##1 st_reg.ramp == 14'h0000);
endmodule : pattern_generators

// file: hw/line_selector.sv
module line_selector (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [2:0]  sel,
	input  wire logic        prbs_on,
	input  wire logic [15:0] custom,
	input  wire logic [13:0] ramp_word,
	input  wire logic        toggle_bit,
	input  wire logic [15:0] prbs_word,
	input  wire logic [13:0] sample,
	output logic [13:0]      word_out
);
	typedef struct packed {
		logic [13:0] word;
	} sel_st_t;

	sel_st_t st_reg;
	sel_st_t st_next;

	// ==========================================================
	// Pattern mux; pseudo-random overrides custom or ramp base
	always_comb begin
		st_next = st_reg;
		case (sel)
			pattern_pkg::PAT_NONE:   st_next.word = sample;
			pattern_pkg::PAT_RAMP:   st_next.word = ramp_word;
			pattern_pkg::PAT_TOGGLE: st_next.word = {14{toggle_bit}};
			default:                 st_next.word = pattern_pkg::fixed_word(sel, custom);
		endcase
		if (prbs_on && (sel == pattern_pkg::PAT_CUSTOM || sel == pattern_pkg::PAT_RAMP)) begin
			st_next.word = prbs_word[15:2];
		end
	end

	// Registered so every line sees identical latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign word_out = st_reg.word;

	chk_pass_through: assert property (@(posedge pclk) disable iff (!presetn)
		sel == pattern_pkg::PAT_NONE |=> word_out == $past(sample))
		else $error("sample not passed unchanged");
	chk_deskew_word: assert property (@(posedge pclk) disable iff (!presetn)
		sel == pattern_pkg::PAT_DESKEW |=> word_out == 14'h1555)
		else $error("deskew word wrong");
	chk_sync_word: assert property (@(posedge pclk) disable iff (!presetn)
		sel == pattern_pkg::PAT_SYNC |=> word_out == 14'h3F80)
		else $error("sync word wrong");
	chk_custom_msb: assert property (@(posedge pclk) disable iff (!presetn)
		(sel == pattern_pkg::PAT_CUSTOM && !prbs_on) |=> word_out == $past(custom[15:2]))
		else $error("custom word not msb aligned");
	chk_prbs_word: assert property (@(posedge pclk) disable iff (!presetn)
		(sel == pattern_pkg::PAT_RAMP && prbs_on) |=> word_out == $past(prbs_word[15:2]))
		else $error("prbs word not substituted");
	cov_toggle_used: cover property (@(posedge pclk) disable iff (!presetn)
		sel == pattern_pkg::PAT_TOGGLE [*3]);
endmodule : line_selector

// file: hw/serial_output_test_pattern_gen.sv
// Register access over APB and the register addresses were decided locally.
module serial_output_test_pattern_gen (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic [223:0] sample_in,
	output logic [223:0]      line_out
);
	localparam int NL = pattern_pkg::NUM_LINES;

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0]    ctrl;
		logic [15:0]   custom;
		logic [47:0]   lsel;
		logic [15:0]   lprbs;
		logic [2:0]    last_gsel;
		logic [31:0]   rdata;
		logic          ready;
		logic          err;
	} top_st_t;

	top_st_t st_reg;
	top_st_t st_next;

	logic          access;
	logic          wr_strobe;
	logic [31:0]   wmask;
	logic [NL*14-1:0] sel_words;

	gen_if gio ();

	// ==========================================================
	// APB decode; one wait cycle so data comes from a flop
	assign access = psel && penable && !st_reg.ready;
	assign wr_strobe = access && pwrite;

	// Byte-lane mask from pstrb
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	assign wmask = lane_mask(pstrb);

	always_comb begin
		logic [31:0] tmp;
		tmp = '0;
		st_next = st_reg;
		st_next.ready = access;
		st_next.err = 1'b0;
		st_next.rdata = '0;
		// Restart is a self-clearing pulse
		st_next.ctrl[pattern_pkg::CTRL_RESTART] = 1'b0;
		st_next.last_gsel = st_reg.ctrl[2:0];
		if (access) begin
			case (paddr)
				pattern_pkg::OFS_CTRL: begin
					tmp = merge({24'h000000, st_reg.ctrl}, pwdata, wmask);
					if (pwrite) begin
						st_next.ctrl = tmp[7:0];
					end
					st_next.rdata = {24'h000000, st_reg.ctrl};
				end
				pattern_pkg::OFS_CUSTOM: begin
					tmp = merge({16'h0000, st_reg.custom}, pwdata, wmask);
					if (pwrite) begin
						st_next.custom = tmp[15:0];
					end
					st_next.rdata = {16'h0000, st_reg.custom};
				end
				pattern_pkg::OFS_LSEL_LO: begin
					tmp = merge({8'h00, st_reg.lsel[23:0]}, pwdata, wmask);
					if (pwrite) begin
						st_next.lsel[23:0] = tmp[23:0];
					end
					st_next.rdata = {8'h00, st_reg.lsel[23:0]};
				end
				pattern_pkg::OFS_LSEL_HI: begin
					tmp = merge({8'h00, st_reg.lsel[47:24]}, pwdata, wmask);
					if (pwrite) begin
						st_next.lsel[47:24] = tmp[23:0];
					end
					st_next.rdata = {8'h00, st_reg.lsel[47:24]};
				end
				pattern_pkg::OFS_LPRBS: begin
					tmp = merge({16'h0000, st_reg.lprbs}, pwdata, wmask);
					if (pwrite) begin
						st_next.lprbs = tmp[15:0];
					end
					st_next.rdata = {16'h0000, st_reg.lprbs};
				end
				pattern_pkg::OFS_STATUS: begin
					// Read-only: generator running flag and current ramp value
					st_next.rdata = {15'h0000, gio.running, 2'b00, gio.ramp_word};
					st_next.err = pwrite;
				end
				default: begin
					st_next.err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{8'h00, pattern_pkg::CUSTOM_RESET[15:0], 48'h0, 16'h0000,
				3'h0, 32'h00000000, 1'b0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.err;

	// ==========================================================
	// Shared generators
	assign gio.restart = st_reg.ctrl[pattern_pkg::CTRL_RESTART];
	assign gio.len9 = st_reg.ctrl[pattern_pkg::CTRL_LEN9];
	// New global selection restarts the toggle phase
	assign gio.toggle_clear = st_reg.ctrl[2:0] != st_reg.last_gsel;

	pattern_generators u_gen (
		.pclk    (pclk),
		.presetn (presetn),
		.gio     (gio)
	);

	// ==========================================================
	// Per-line selection and substitution
	genvar g;
	generate
		for (g = 0; g < NL; g++) begin : g_line
			logic [2:0] sel;
			logic       prbs_on;
			// Individual mode uses per-line fields and enables
			assign sel = st_reg.ctrl[pattern_pkg::CTRL_IND] ? st_reg.lsel[g*3 +: 3]
				: st_reg.ctrl[2:0];
			// Global random needs both select and enable, as software sequences them
			assign prbs_on = st_reg.ctrl[pattern_pkg::CTRL_IND] ? st_reg.lprbs[g]
				: (st_reg.ctrl[pattern_pkg::CTRL_GPRBS]
				&& st_reg.ctrl[pattern_pkg::CTRL_RAND_EN]);
			line_selector u_sel (
				.pclk       (pclk),
				.presetn    (presetn),
				.sel        (sel),
				.prbs_on    (prbs_on),
				.custom     (st_reg.custom),
				.ramp_word  (gio.ramp_word),
				.toggle_bit (gio.toggle_bit),
				.prbs_word  (gio.prbs_word),
				.sample     (sample_in[g*14 +: 14]),
				.word_out   (sel_words[g*14 +: 14])
			);
		end
	endgenerate

	assign line_out = sel_words;

	// ==========================================================
	// Checks
	chk_common_lines: assert property (@(posedge pclk) disable iff (!presetn)
		(!st_reg.ctrl[3] && st_reg.ctrl[2:0] == pattern_pkg::PAT_TOGGLE)
		|=> line_out[13:0] == line_out[223:210])
		else $error("lines differ in common mode");
	chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("apb access not answered in one cycle");
	chk_restart_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg.ctrl[pattern_pkg::CTRL_RESTART] |=> !st_reg.ctrl[pattern_pkg::CTRL_RESTART])
		else $error("restart did not self clear");
	cov_ind_mode: cover property (@(posedge pclk) disable iff (!presetn)
		st_reg.ctrl[pattern_pkg::CTRL_IND] ##1 st_reg.lprbs != 16'h0000);
	cov_write: cover property (@(posedge pclk) disable iff (!presetn)
		wr_strobe && paddr == pattern_pkg::OFS_CUSTOM);
endmodule : serial_output_test_pattern_gen

// file: test/deser_model.sv
// ==========================================================
// Far-side deserializer: one word per line per conversion clock
module deser_model (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [223:0] line_in,
	output logic [223:0]      frame_word
);
	timeunit 1ns;
	timeprecision 1ps;

	// Frame capture; cleared in reset so stale words never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_word <= '0;
		end else begin
			frame_word <= line_in;
		end
	end
endmodule : deser_model

// file: test/serial_output_test_pattern_gen_tb.sv
// ==========================================================
// Bench top
module serial_output_test_pattern_gen_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic         pclk      = 1'b0;
	logic         presetn   = 1'b0;
	logic         psel      = 1'b0;
	logic         penable   = 1'b0;
	logic         pwrite    = 1'b0;
	logic [11:0]  paddr     = 12'h000;
	logic [31:0]  pwdata    = 32'h0;
	logic [3:0]   pstrb     = 4'hF;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic [223:0] sample_in;
	logic [223:0] line_out;
	logic [223:0] fw;
	logic [31:0]  rd;
	logic         err;
	logic [13:0]  a;
	logic [13:0]  b;
	logic [13:0]  exp_w;
	logic [13:0]  fixed_exp [1:5] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h3F80, 14'h32D7};
	int           error_cnt = 0;
	int           checks    = 0;

	serial_output_test_pattern_gen u_serial_output_test_pattern_gen (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_in(sample_in), .line_out(line_out));

	deser_model u_deser_model (
		.pclk(pclk), .presetn(presetn), .line_in(line_out), .frame_word(fw));

	// Clock, 40 ns period
	always #20 pclk = ~pclk;

	// ==========================================================
	// Helpers
	task automatic check(input string name, input logic [223:0] seen, input logic [223:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One APB transfer; the wait is bounded so a dead slave cannot hang us
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Config lands, then line register, then far-side capture
	task automatic settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	task automatic step;
		@(posedge pclk);
		#1;
	endtask : step

	// Restart the generator and take line 5 a fixed time later
	task automatic prbs_after(input logic [31:0] ctrl, output logic [13:0] w);
		apb(1'b1, pattern_pkg::OFS_CTRL, ctrl);
		repeat (30) @(posedge pclk);
		#1;
		w = fw[70+:14];
	endtask : prbs_after

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// Watchdog, far beyond the roughly 260 cycles the tests need
	initial begin
		#(40 * 5000);
		error_cnt++;
		complete_run();
	end

	// ==========================================================
	// Tests
	initial begin
		for (int g = 0; g < 16; g++) sample_in[g*14+:14] = 14'h0100 + 14'(g);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pattern_pkg::OFS_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0);
		check("ctrl read no error", err, 1'h0);
		apb(1'b0, pattern_pkg::OFS_STATUS, 32'h0);
		check("generator running", rd[16], 1'h1);
		check("status read no error", err, 1'h0);
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped error", err, 1'h1);
		apb(1'b1, pattern_pkg::OFS_STATUS, 32'h0);
		check("status write error", err, 1'h1);
		settle();
		check("pass through", fw, sample_in);
		$display("test reset done");
		// Every fixed word on all lines; samples are nonzero so replacement shows
		apb(1'b1, pattern_pkg::OFS_CUSTOM, 32'h0000CB5C);
		for (int s = 1; s < 6; s++) begin
			apb(1'b1, pattern_pkg::OFS_CTRL, 32'(s));
			settle();
			check("global fixed", fw, {16{fixed_exp[s]}});
		end
		$display("test fixed done");
		apb(1'b1, pattern_pkg::OFS_CTRL, 32'h6);
		settle();
		a = fw[13:0];
		for (int i = 0; i < 6; i++) begin
			step();
			check("ramp step", fw, {16{a + pattern_pkg::RAMP_STEP}});
			a = fw[13:0];
		end
		$display("test ramp done");
		apb(1'b1, pattern_pkg::OFS_CTRL, 32'h7);
		settle();
		a = fw[13:0];
		check("toggle word", (a === 14'h0000 || a === 14'h3FFF), 1'h1);
		for (int i = 0; i < 4; i++) begin
			step();
			check("toggle", fw, {16{~a}});
			a = ~a;
		end
		$display("test toggle done");
		// Per-line selects 0..7 repeat; global zeros must be ignored
		apb(1'b1, pattern_pkg::OFS_LSEL_LO, 32'h00FAC688);
		apb(1'b1, pattern_pkg::OFS_LSEL_HI, 32'h00FAC688);
		apb(1'b1, pattern_pkg::OFS_CTRL, 32'h9);
		settle();
		for (int g = 0; g < 16; g++) begin
			if (g % 8 < 6) begin
				exp_w = (g % 8 == 0) ? sample_in[g*14+:14] : fixed_exp[g%8];
				check("line select", fw[g*14+:14], exp_w);
			end
		end
		$display("test per line done");
		apb(1'b1, pattern_pkg::OFS_LPRBS, 32'h20);
		settle();
		a = fw[70+:14];
		step();
		check("line random moves", a !== fw[70+:14], 1'h1);
		check("neighbour kept", fw[56+:14], fixed_exp[4]);
		prbs_after(32'h89, a);
		prbs_after(32'h89, b);
		check("restart repeats", b, a);
		prbs_after(32'hC9, b);
		prbs_after(32'hC9, exp_w);
		check("short restart repeats", exp_w, b);
		check("lengths differ", a !== b, 1'h1);
		$display("test line random done");
		// Global random: select bit, custom base, then enable
		apb(1'b1, pattern_pkg::OFS_CTRL, 32'h15);
		apb(1'b1, pattern_pkg::OFS_CTRL, 32'h35);
		settle();
		a = fw[13:0];
		check("global random common", fw, {16{a}});
		step();
		check("global random moves", a !== fw[13:0], 1'h1);
		$display("test global random done");
		complete_run();
	end
endmodule : serial_output_test_pattern_gen_tb
